// ### tdp_regs.svh
`ifndef TDP_REGS_SVH
`define TDP_REGS_SVH

// Bus address width
`define TDP_ADR_W 12
// Bit that selects the external region
`define TDP_EXT_BIT 8

// Core region offsets
`define TDP_CTRL 12'h000
`define TDP_STIM 12'h004
`define TDP_WP_ADDR 12'h008
`define TDP_WP_DATA 12'h00C
`define TDP_FLT_ADDR 12'h010
`define TDP_FLT_STAT 12'h014
`define TDP_PWR 12'h018
`define TDP_BP0 12'h020

// External region offsets
`define TDP_TPU_CTRL 12'h100
`define TDP_PRESC 12'h104
`define TDP_STATUS 12'h108
`define TDP_WPTR 12'h10C
`define TDP_RPTR 12'h110
`define TDP_BDATA 12'h114

// Core control fields
`define TDP_ITR_EN 0
`define TDP_FLT_EN 1
`define TDP_INV_S 2
`define TDP_INV_NS 3
`define TDP_WPA_EN 4
`define TDP_WPD_EN 5

// Port unit control fields
`define TDP_OUT_EN 0
`define TDP_SER_SEL 1
`define TDP_UART 2
`define TDP_P4 3

// Writable masks, all resets are zero except prescaler
`define TDP_CTRL_MASK 32'h0000003F
`define TDP_TPU_MASK 32'h0000000F
`define TDP_PRESC_MASK 32'h0000FFFF
`define TDP_PWR_MASK 32'h00000001
`define TDP_RST_ZERO 32'h00000000
`define TDP_PRESC_RST 32'h00000003

// Sizes and counts
`define TDP_BUF_KB 32
`define TDP_BUF_WORDS (`TDP_BUF_KB * 1024 / 4)
`define TDP_PTR_W 14
`define TDP_BP_NUM 4
`define TDP_UART_BITS 5'h0A
`define TDP_MAN_BITS 5'h09
`define TDP_P1_STEPS 5'h08
`define TDP_P4_STEPS 5'h02

`endif

// ### tdp_pkg.sv
package tdp_pkg;

    // Bus word
    typedef logic [31:0] tdp_word_t;

    // Output shifter states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PAR = 3'b010,
        ST_SER = 3'b100
    } tdp_state_t;

endpackage : tdp_pkg

// ### tdp_top.sv
`timescale 1ns/100ps
`include "tdp_regs.svh"
module tdp_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`TDP_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire tdp_pkg::tdp_word_t wb_dat_i,
    output tdp_pkg::tdp_word_t wb_dat_o,
    output logic wb_ack_o,
    // Core fetch stream
    input wire logic fetch_valid_i,
    input wire tdp_pkg::tdp_word_t fetch_addr_i,
    input wire logic fetch_secure_i,
    // Core data accesses
    input wire logic dacc_valid_i,
    input wire tdp_pkg::tdp_word_t dacc_addr_i,
    input wire tdp_pkg::tdp_word_t dacc_data_i,
    // System bus faults
    input wire logic [2:0] bus_fault_i,
    input wire tdp_pkg::tdp_word_t fault_addr0_i,
    input wire tdp_pkg::tdp_word_t fault_addr1_i,
    input wire tdp_pkg::tdp_word_t fault_addr2_i,
    // Power and link status
    input wire logic deep_sleep_i,
    input wire logic swd_attached_i,
    input wire logic trace_clk_i,
    // Trace and debug outputs
    output logic [3:0] trace_data_o,
    output logic swo_o,
    output logic bkpt_halt_o,
    output logic wp_hit_o
);
    import tdp_pkg::*;

    // Byte-lane merge for partial writes
    function automatic tdp_word_t merge(input tdp_word_t old, input tdp_word_t nw,
                                        input logic [3:0] sel);
        tdp_word_t r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Word address compare
    function automatic logic hit(input logic [`TDP_ADR_W-1:0] a,
                                 input logic [`TDP_ADR_W-1:0] off);
        return a[`TDP_ADR_W-1:2] == off[`TDP_ADR_W-1:2];
    endfunction : hit

    // Breakpoint comparator, bit 0 enables
    function automatic logic bp_match(input tdp_word_t comp, input tdp_word_t addr);
        return comp[0] && (comp[31:1] == addr[31:1]);
    endfunction : bp_match

    // Synchroniser chain for {attach, trace clock}
    logic [1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
    logic tclk_prev_ff; // Last filtered trace clock
    logic tclk_rise; // Filtered rising edge
    logic dbg_pwr_on; // Debug domain powered

    // Bus state
    logic ack_ff;
    tdp_word_t rdata_ff;
    tdp_word_t nxt_rdata;
    logic req, hang, wr, rd;
    logic [`TDP_ADR_W-1:0] adr_w; // Word-aligned address

    // Software registers
    tdp_word_t ctrl_ff, wpa_ff, wpd_ff, pwr_ff, tpu_ff, presc_ff;
    tdp_word_t bp_ff [`TDP_BP_NUM];
    tdp_word_t flt_addr_ff;
    logic [2:0] flt_stat_ff; // {bus index, valid}

    // Software trace byte waiting for the port
    logic sw_pend_ff;
    logic [7:0] sw_byte_ff;

    // Trace buffer
    tdp_word_t buf_mem [`TDP_BUF_WORDS];
    logic [`TDP_PTR_W-1:0] wptr_ff, rptr_ff;
    logic [1:0] bsel_ff; // Next byte of current word
    logic ovf_ff; // Capture dropped while full
    logic buf_empty, buf_full, cap, bus_pop, drain;

    // Output shifter
    tdp_state_t state_ff;
    logic [9:0] sh_ff;
    logic [4:0] cnt_ff;
    logic half_ff; // Manchester second half
    logic [15:0] div_ff;
    logic tick; // Serial bit-time enable
    logic swo_ff;
    logic [3:0] tdata_ff;
    logic bkpt_ff, wp_ff, swo_iso_ff;
    logic bp_any, wp_hit, out_go, load;
    logic [7:0] load_byte;

    // Three-stage sampling; level moves when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_ff <= 2'h0;
            s2_ff <= 2'h0;
            s3_ff <= 2'h0;
            lvl_ff <= 2'h0;
            tclk_prev_ff <= 1'b0;
        end else begin
            s1_ff <= {swd_attached_i, trace_clk_i};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
            tclk_prev_ff <= lvl_ff[0];
        end
    end

    assign tclk_rise = lvl_ff[0] & ~tclk_prev_ff;
    // Domain is up by software or by an attached debugger
    assign dbg_pwr_on = pwr_ff[0] | lvl_ff[1];

    // Bus decode
    assign adr_w = {wb_adr_i[`TDP_ADR_W-1:2], 2'b00};
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    // Port-unit region write while unpowered stalls until the domain is powered
    assign hang = req & wb_we_i & wb_adr_i[`TDP_EXT_BIT] & ~dbg_pwr_on;
    assign wr = req & wb_we_i & ~hang;
    assign rd = req & ~wb_we_i;

    // Ack one cycle after the request, dropped the next
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rdata_ff <= `TDP_RST_ZERO;
        end else begin
            ack_ff <= wr | rd;
            if (rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;

    // Read mux, unmapped reads return zero
    always_comb begin
        nxt_rdata = `TDP_RST_ZERO;
        case (adr_w)
            `TDP_CTRL: nxt_rdata = ctrl_ff;
            `TDP_WP_ADDR: nxt_rdata = wpa_ff;
            `TDP_WP_DATA: nxt_rdata = wpd_ff;
            `TDP_FLT_ADDR: nxt_rdata = flt_addr_ff;
            `TDP_FLT_STAT: nxt_rdata = {29'h0, flt_stat_ff};
            `TDP_PWR: nxt_rdata = pwr_ff;
            `TDP_TPU_CTRL: nxt_rdata = tpu_ff;
            `TDP_PRESC: nxt_rdata = presc_ff;
            `TDP_STATUS: nxt_rdata = {27'h0, buf_empty, ovf_ff, dbg_pwr_on,
                                      sw_pend_ff, state_ff != ST_IDLE};
            `TDP_WPTR: nxt_rdata = {18'h0, wptr_ff};
            `TDP_RPTR: nxt_rdata = {18'h0, rptr_ff};
            `TDP_BDATA: nxt_rdata = buf_mem[rptr_ff[`TDP_PTR_W-2:0]];
            default: begin
                // Comparator block
                if (adr_w[`TDP_ADR_W-1:4] == 8'(`TDP_BP0 >> 4)) begin
                    nxt_rdata = bp_ff[adr_w[3:2]];
                end
            end
        endcase
    end

    // Writable configuration registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= `TDP_RST_ZERO;
            wpa_ff <= `TDP_RST_ZERO;
            wpd_ff <= `TDP_RST_ZERO;
            pwr_ff <= `TDP_RST_ZERO;
            tpu_ff <= `TDP_RST_ZERO;
            presc_ff <= `TDP_PRESC_RST;
            for (int i = 0; i < `TDP_BP_NUM; i++) begin
                bp_ff[i] <= `TDP_RST_ZERO;
            end
        end else if (wr) begin
            if (hit(wb_adr_i, `TDP_CTRL)) begin
                ctrl_ff <= merge(ctrl_ff, wb_dat_i, wb_sel_i) & `TDP_CTRL_MASK;
            end
            if (hit(wb_adr_i, `TDP_WP_ADDR)) begin
                wpa_ff <= merge(wpa_ff, wb_dat_i, wb_sel_i);
            end
            if (hit(wb_adr_i, `TDP_WP_DATA)) begin
                wpd_ff <= merge(wpd_ff, wb_dat_i, wb_sel_i);
            end
            if (hit(wb_adr_i, `TDP_PWR)) begin
                pwr_ff <= merge(pwr_ff, wb_dat_i, wb_sel_i) & `TDP_PWR_MASK;
            end
            if (hit(wb_adr_i, `TDP_TPU_CTRL)) begin
                // Coding choice is taken from here at frame start and again at each serial tick
                tpu_ff <= merge(tpu_ff, wb_dat_i, wb_sel_i) & `TDP_TPU_MASK;
            end
            if (hit(wb_adr_i, `TDP_PRESC)) begin
                presc_ff <= merge(presc_ff, wb_dat_i, wb_sel_i) & `TDP_PRESC_MASK;
            end
            for (int i = 0; i < `TDP_BP_NUM; i++) begin
                if (hit(wb_adr_i, `TDP_BP0 + 12'(i * 4))) begin
                    bp_ff[i] <= merge(bp_ff[i], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // Breakpoints gated by invasive-debug enable of current state
    always_comb begin
        bp_any = 1'b0;
        for (int i = 0; i < `TDP_BP_NUM; i++) begin
            bp_any = bp_any | bp_match(bp_ff[i], fetch_addr_i);
        end
    end

    // Watchpoint on address and/or data value
    assign wp_hit = dacc_valid_i &
                    ((ctrl_ff[`TDP_WPA_EN] & (dacc_addr_i == wpa_ff)) |
                     (ctrl_ff[`TDP_WPD_EN] & (dacc_data_i == wpd_ff)));

    // Registered event pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bkpt_ff <= 1'b0;
            wp_ff <= 1'b0;
        end else begin
            bkpt_ff <= fetch_valid_i & bp_any &
                       (fetch_secure_i ? ctrl_ff[`TDP_INV_S] : ctrl_ff[`TDP_INV_NS]);
            wp_ff <= wp_hit;
        end
    end

    assign bkpt_halt_o = bkpt_ff;
    assign wp_hit_o = wp_ff;

    // Fault address trap; capture flops idle unless enabled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flt_addr_ff <= `TDP_RST_ZERO;
            flt_stat_ff <= 3'h0;
        end else if (ctrl_ff[`TDP_FLT_EN] && (bus_fault_i != 3'h0) &&
                     (!flt_stat_ff[0] ||
                      (wr && hit(wb_adr_i, `TDP_FLT_STAT) && wb_sel_i[0] && wb_dat_i[0]))) begin
            // New fault beats a clear in the same cycle
            if (bus_fault_i[0]) begin
                flt_addr_ff <= fault_addr0_i;
                flt_stat_ff <= 3'b001;
            end else if (bus_fault_i[1]) begin
                flt_addr_ff <= fault_addr1_i;
                flt_stat_ff <= 3'b011;
            end else begin
                flt_addr_ff <= fault_addr2_i;
                flt_stat_ff <= 3'b101;
            end
        end else if (wr && hit(wb_adr_i, `TDP_FLT_STAT) && wb_sel_i[0] && wb_dat_i[0]) begin
            flt_stat_ff[0] <= 1'b0;
        end
    end

    // Buffer pointers and status
    assign buf_empty = wptr_ff == rptr_ff;
    assign buf_full = (wptr_ff[`TDP_PTR_W-1] != rptr_ff[`TDP_PTR_W-1]) &&
                      (wptr_ff[`TDP_PTR_W-2:0] == rptr_ff[`TDP_PTR_W-2:0]);
    // Only fetch addresses are recorded, no data values
    assign cap = ctrl_ff[`TDP_ITR_EN] & fetch_valid_i;
    assign bus_pop = rd & hit(wb_adr_i, `TDP_BDATA) & ~buf_empty;

    // Trace buffer storage
    always_ff @(posedge clk_i) begin
        if (cap && !buf_full) begin
            buf_mem[wptr_ff[`TDP_PTR_W-2:0]] <= fetch_addr_i;
        end
    end

    // Write pointer and overflow flag; overflow beats its clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr_ff <= `TDP_PTR_W'(0);
            ovf_ff <= 1'b0;
        end else begin
            if (cap && !buf_full) begin
                wptr_ff <= wptr_ff + `TDP_PTR_W'(1);
            end
            if (cap && buf_full) begin
                ovf_ff <= 1'b1;
            end else if (wr && hit(wb_adr_i, `TDP_STATUS) && wb_sel_i[0] && wb_dat_i[3]) begin
                ovf_ff <= 1'b0;
            end
        end
    end

    // Read pointer: bus pops whole words, port drains bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rptr_ff <= `TDP_PTR_W'(0);
            bsel_ff <= 2'h0;
        end else if (wr && hit(wb_adr_i, `TDP_RPTR)) begin
            rptr_ff <= wb_dat_i[`TDP_PTR_W-1:0];
            bsel_ff <= 2'h0;
        end else if (bus_pop) begin
            rptr_ff <= rptr_ff + `TDP_PTR_W'(1);
            bsel_ff <= 2'h0;
        end else if (drain) begin
            bsel_ff <= bsel_ff + 2'h1;
            if (bsel_ff == 2'h3) begin
                rptr_ff <= rptr_ff + `TDP_PTR_W'(1);
            end
        end
    end

    // Software trace byte from stimulus writes or watchpoint data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_pend_ff <= 1'b0;
            sw_byte_ff <= 8'h00;
        end else if (wr && hit(wb_adr_i, `TDP_STIM) && wb_sel_i[0]) begin
            sw_pend_ff <= 1'b1;
            sw_byte_ff <= wb_dat_i[7:0];
        end else if (wp_hit) begin
            sw_pend_ff <= 1'b1;
            sw_byte_ff <= dacc_data_i[7:0];
        end else if (load && sw_pend_ff) begin
            sw_pend_ff <= 1'b0;
        end
    end

    // Source arbitration, software trace ahead of instruction trace
    assign out_go = tpu_ff[`TDP_OUT_EN] & dbg_pwr_on;
    assign load = (state_ff == ST_IDLE) && out_go && (sw_pend_ff || !buf_empty) && !bus_pop;
    assign drain = load && !sw_pend_ff;
    assign load_byte = sw_pend_ff ? sw_byte_ff :
                       8'(buf_mem[rptr_ff[`TDP_PTR_W-2:0]] >> {bsel_ff, 3'b000});

    // Serial bit-time divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 16'h0000;
        end else if (state_ff != ST_SER || div_ff == 16'h0000) begin
            div_ff <= presc_ff[15:0];
        end else begin
            div_ff <= div_ff - 16'h0001;
        end
    end

    assign tick = (state_ff == ST_SER) && (div_ff == 16'h0000);

    // Output shifter: parallel on trace clock rising edges, serial on ticks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            sh_ff <= 10'h000;
            cnt_ff <= 5'h00;
            half_ff <= 1'b0;
            tdata_ff <= 4'h0;
            swo_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // Idle level: high for UART, low for Manchester
                    swo_ff <= tpu_ff[`TDP_UART];
                    half_ff <= 1'b0;
                    if (load && tpu_ff[`TDP_SER_SEL]) begin
                        state_ff <= ST_SER;
                        if (tpu_ff[`TDP_UART]) begin
                            sh_ff <= {1'b1, load_byte, 1'b0};
                            cnt_ff <= `TDP_UART_BITS;
                        end else begin
                            sh_ff <= {1'b0, load_byte, 1'b1};
                            cnt_ff <= `TDP_MAN_BITS;
                        end
                    end else if (load) begin
                        state_ff <= ST_PAR;
                        sh_ff <= {2'b00, load_byte};
                        cnt_ff <= tpu_ff[`TDP_P4] ? `TDP_P4_STEPS : `TDP_P1_STEPS;
                    end
                end
                ST_PAR: begin
                    if (tclk_rise) begin
                        if (tpu_ff[`TDP_P4]) begin
                            tdata_ff <= sh_ff[3:0];
                            sh_ff <= sh_ff >> 4;
                        end else begin
                            tdata_ff <= {3'b000, sh_ff[0]};
                            sh_ff <= sh_ff >> 1;
                        end
                        cnt_ff <= cnt_ff - 5'h01;
                        if (cnt_ff == 5'h01) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                ST_SER: begin
                    if (tick) begin
                        if (tpu_ff[`TDP_UART]) begin
                            swo_ff <= sh_ff[0];
                            sh_ff <= sh_ff >> 1;
                            cnt_ff <= cnt_ff - 5'h01;
                        end else begin
                            // Two halves per bit, second inverted
                            swo_ff <= half_ff ? ~sh_ff[0] : sh_ff[0];
                            half_ff <= ~half_ff;
                            if (half_ff) begin
                                sh_ff <= sh_ff >> 1;
                                cnt_ff <= cnt_ff - 5'h01;
                            end
                        end
                        if (cnt_ff == 5'h01 && (tpu_ff[`TDP_UART] || half_ff)) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Deep-sleep isolation pulls the serial pin low when serial mode is selected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swo_iso_ff <= 1'b0;
        end else if (deep_sleep_i && tpu_ff[`TDP_SER_SEL]) begin
            swo_iso_ff <= 1'b0;
        end else begin
            swo_iso_ff <= swo_ff;
        end
    end

    assign swo_o = swo_iso_ff;
    assign trace_data_o = tdata_ff;

endmodule : tdp_top

// ### tdp_properties.sv
`timescale 1ns/100ps
`include "tdp_regs.svh"
module tdp_chk import tdp_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`TDP_ADR_W-1:0] wb_adr_i,
    input wire tdp_word_t wb_dat_o,
    input wire logic wb_ack_o,
    // Core events
    input wire logic fetch_valid_i,
    input wire logic dacc_valid_i,
    input wire logic deep_sleep_i,
    // Outputs
    input wire logic [3:0] trace_data_o,
    input wire logic swo_o,
    input wire logic bkpt_halt_o,
    input wire logic wp_hit_o
);
    // One clock domain
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request pending and not yet acked; the latency check leaves out every external-region write
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    AST_ACK_LAT: assert property (req_s ##0 !(wb_we_i && wb_adr_i[`TDP_EXT_BIT]) |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    AST_ACK_REQ: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_UNMAP: assert property (req_s ##0 !wb_we_i && wb_adr_i == 12'h0FC |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_BKPT_SRC: assert property (bkpt_halt_o |-> $past(fetch_valid_i))
        else $error("halt without fetch");
    AST_WP_SRC: assert property (wp_hit_o |-> $past(dacc_valid_i) || $past(dacc_valid_i, 2))
        else $error("hit without access");
    AST_SLEEP_LOW: assert property ($past(deep_sleep_i) && deep_sleep_i |-> !swo_o)
        else $error("serial pin high in sleep");
    AST_RST_QUIET: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && trace_data_o == 4'h0 && !swo_o && !bkpt_halt_o)
        else $error("outputs active in reset");
    // Main scenarios
    COV_ACK: cover property (wb_ack_o);
    COV_BKPT: cover property (bkpt_halt_o);
    COV_WP: cover property (wp_hit_o);
    COV_SLEEP: cover property (deep_sleep_i && !swo_o);
endmodule : tdp_chk
bind tdp_top tdp_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .fetch_valid_i, .dacc_valid_i, .deep_sleep_i, .trace_data_o,
    .swo_o, .bkpt_halt_o, .wp_hit_o);

// ### tdp_probe.sv
`timescale 1ns/100ps
module tdp_probe (
    // Capture control
    input wire logic run_i,
    input wire logic [3:0] trace_data_i,
    // Probe side of the port
    output logic trace_clk_o,
    output logic [7:0] got_o
);
    // Trace clock, 200 ns, still between bursts
    initial begin
        trace_clk_o = 1'b0;
        forever #100 if (run_i || trace_clk_o) trace_clk_o = ~trace_clk_o;
    end
    // Takes the unit of the previous edge
    always @(posedge trace_clk_o) got_o <= {trace_data_i, got_o[7:4]};
endmodule : tdp_probe

// ### tdp_tb.sv
`timescale 1ns/100ps
`include "tdp_regs.svh"
module testbench;
    import tdp_pkg::*;
    // Stimulus
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, fv = 1'b0, fs = 1'b0;
    logic dv = 1'b0, ds = 1'b0, sw = 1'b0, run = 1'b0, ack, bk, wh, swo, tck;
    logic [11:0] adr = 12'h000;
    logic [2:0] bf = 3'h0;
    logic [3:0] td;
    logic [7:0] got;
    logic [8:0] v;
    tdp_word_t dat = 32'h0, fa = 32'h0, da = 32'h0, q, rdat;
    int failures = 0, checks_done = 0;
    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;
    tdp_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .fetch_valid_i(fv), .fetch_addr_i(fa), .fetch_secure_i(fs), .dacc_valid_i(dv),
        .dacc_addr_i(da), .dacc_data_i(32'h0000005A), .bus_fault_i(bf),
        .fault_addr0_i(32'h00000100), .fault_addr1_i(32'h00000200), .fault_addr2_i(fa),
        .deep_sleep_i(ds), .swd_attached_i(sw), .trace_clk_i(tck), .trace_data_o(td),
        .swo_o(swo), .bkpt_halt_o(bk), .wp_hit_o(wh));
    tdp_probe u_probe (.run_i(run), .trace_data_i(td), .trace_clk_o(tck), .got_o(got));
    // Verdict and end of run
    task print_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // Compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Raise a bus request
    task go(input logic w, input logic [11:0] a, input tdp_word_t d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
    endtask : go
    // Wait for ack, then release
    task hold(input int lim, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge clk_i);
            ok = (ack === 1'b1);
        end
        if (ok) begin
            q = rdat;
            cyc <= 1'b0;
            @(posedge clk_i);
        end
    endtask : hold
    // Full bus cycle, timeout ends the run
    task xfer(input logic w, input logic [11:0] a, input tdp_word_t d);
        bit ok;
        go(w, a, d);
        hold(50, ok);
        if (!ok) begin
            failures++;
            print_verdict();
        end
    endtask : xfer
    // Read and compare
    task rd(input logic [11:0] a, input tdp_word_t e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    // One fetch, result seen at return
    task fetch(input tdp_word_t a, input logic s);
        fa <= a;
        fs <= s;
        fv <= 1'b1;
        @(posedge clk_i);
        fv <= 1'b0;
        @(posedge clk_i);
    endtask : fetch
    // Burst of trace clock edges, counted on the system clock
    task clocks(input int n);
        int seen;
        logic last;
        seen = 0;
        last = tck;
        run <= 1'b1;
        for (int k = 0; k < 20 * n + 20 && seen < n; k++) begin
            @(posedge clk_i);
            if (tck === 1'b1 && last === 1'b0) seen++;
            last = tck;
        end
        run <= 1'b0;
        if (seen < n) begin
            failures++;
            print_verdict();
        end else begin
            repeat (8) @(posedge clk_i);
        end
    endtask : clocks
    // Sample the serial pin once per serial tick, a half bit in Manchester
    task grab(input int skip, input int n);
        v = 9'h000;
        repeat (skip) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            v[i] = swo;
            repeat (4) @(posedge clk_i);
        end
    endtask : grab
    // Bounded wait for a serial level
    task wait_swo(input logic lv);
        bit hit;
        hit = 1'b0;
        repeat (60) if (!hit) begin
            @(posedge clk_i);
            hit = (swo === lv);
        end
        if (!hit) begin
            failures++;
            print_verdict();
        end
    endtask : wait_swo
    // Map, reset values, unmapped place
    task t_map;
        rd(`TDP_CTRL, 32'h0);
        rd(`TDP_PRESC, `TDP_PRESC_RST);
        xfer(1'b1, 12'h0FC, 32'hFFFFFFFF);
        rd(12'h0FC, 32'h0);
    endtask : t_map
    // Port unit write while unpowered
    task t_power;
        bit ok;
        go(1'b1, `TDP_TPU_CTRL, 32'h0);
        hold(16, ok);
        chk(ok, 1'b0);
        sw <= 1'b1;
        hold(16, ok);
        chk(ok, 1'b1);
        sw <= 1'b0;
        xfer(1'b1, `TDP_PWR, 32'h1);
        rd(`TDP_TPU_CTRL, 32'h0);
    endtask : t_power
    // Fetch capture, buffer read and overflow
    task t_itrace;
        xfer(1'b1, `TDP_CTRL, 32'h1);
        fetch(32'h00001234, 1'b0);
        da <= 32'h00004444;
        dv <= 1'b1;
        @(posedge clk_i);
        dv <= 1'b0;
        rd(`TDP_WPTR, 32'h1);
        rd(`TDP_BDATA, 32'h00001234);
        fv <= 1'b1;
        repeat (`TDP_BUF_WORDS + 1) @(posedge clk_i);
        fv <= 1'b0;
        xfer(1'b0, `TDP_STATUS, 32'h0);
        chk(q[3], 1'b1);
        rd(`TDP_WPTR, 32'h2001);
        xfer(1'b1, `TDP_CTRL, 32'h0);
        xfer(1'b1, `TDP_RPTR, 32'h2001);
        xfer(1'b0, `TDP_STATUS, 32'h0);
        chk(q[4], 1'b1);
    endtask : t_itrace
    // Comparator and security state
    task t_bkpt;
        xfer(1'b1, `TDP_BP0 + 12'h00C, 32'h00002001);
        xfer(1'b1, `TDP_CTRL, 32'h4);
        fetch(32'h00002000, 1'b1);
        chk(bk, 1'b1);
        fetch(32'h00002000, 1'b0);
        chk(bk, 1'b0);
        fetch(32'h00002004, 1'b1);
        chk(bk, 1'b0);
    endtask : t_bkpt
    // Fault trap off, then on
    task t_fault;
        bf <= 3'h2;
        @(posedge clk_i);
        bf <= 3'h0;
        rd(`TDP_FLT_STAT, 32'h0);
        xfer(1'b1, `TDP_CTRL, 32'h2);
        fa <= 32'h0000BEE0;
        bf <= 3'h4;
        @(posedge clk_i);
        bf <= 3'h0;
        rd(`TDP_FLT_ADDR, 32'h0000BEE0);
        rd(`TDP_FLT_STAT, 32'h5);
    endtask : t_fault
    // Parallel port, 4-bit then 1-bit
    task t_par;
        xfer(1'b1, `TDP_TPU_CTRL, 32'h9);
        xfer(1'b1, `TDP_STIM, 32'hA5);
        clocks(3);
        chk(got, 8'hA5);
        xfer(1'b1, `TDP_TPU_CTRL, 32'h1);
        xfer(1'b1, `TDP_STIM, 32'hFF);
        clocks(8);
        chk(td, 4'h1);
    endtask : t_par
    // Serial frames and deep sleep
    task t_ser;
        xfer(1'b1, `TDP_PRESC, 32'h3);
        xfer(1'b1, `TDP_TPU_CTRL, 32'h7);
        xfer(1'b1, `TDP_STIM, 32'h3C);
        wait_swo(1'b0);
        grab(6, 9);
        chk(v, 9'h13C);
        ds <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(swo, 1'b0);
        ds <= 1'b0;
        xfer(1'b1, `TDP_TPU_CTRL, 32'h3);
        xfer(1'b1, `TDP_STIM, 32'h01);
        wait_swo(1'b1);
        grab(2, 6);
        chk(v, 9'h025);
    endtask : t_ser
    // Address watchpoint, then data value watchpoint
    task t_wp;
        bit hit;
        xfer(1'b1, `TDP_WP_ADDR, 32'h00003000);
        xfer(1'b1, `TDP_CTRL, 32'h10);
        da <= 32'h00003000;
        dv <= 1'b1;
        @(posedge clk_i);
        dv <= 1'b0;
        hit = 1'b0;
        repeat (3) begin
            @(posedge clk_i);
            hit = hit | (wh === 1'b1);
        end
        chk(hit, 1'b1);
        xfer(1'b1, `TDP_WP_DATA, 32'h0000005A);
        xfer(1'b1, `TDP_CTRL, 32'h20);
        da <= 32'h00000000;
        dv <= 1'b1;
        @(posedge clk_i);
        dv <= 1'b0;
        @(posedge clk_i);
        chk(wh, 1'b1);
    endtask : t_wp
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_map();
        t_power();
        t_itrace();
        t_bkpt();
        t_fault();
        t_par();
        t_ser();
        t_wp();
        print_verdict();
    end
endmodule : testbench
